// file: include/smwp_defines.svh
/*
  constants of the static memory wait and page controller: wait modes,
  fixed slow clock lengths, reset values.
  assumes inclusion by bare name from the design file.
*/
`ifndef SMWP_DEFINES_SVH
`define SMWP_DEFINES_SVH

// external wait mode field codes
`define SMWP_WAIT_FROZEN 2'h2
`define SMWP_WAIT_READY 2'h3

// fixed slow clock read lengths, in cycles
`define SMWP_SLOW_RD_STR_SETUP 10'h001
`define SMWP_SLOW_RD_STR_PULSE 10'h001
`define SMWP_SLOW_RD_CS_SETUP 10'h000
`define SMWP_SLOW_RD_CS_PULSE 10'h002
`define SMWP_SLOW_RD_CYCLE 10'h002

// fixed slow clock write lengths, in cycles
`define SMWP_SLOW_WR_STR_SETUP 10'h001
`define SMWP_SLOW_WR_STR_PULSE 10'h001
`define SMWP_SLOW_WR_CS_SETUP 10'h000
`define SMWP_SLOW_WR_CS_PULSE 10'h003
`define SMWP_SLOW_WR_CYCLE 10'h003

// smallest page in bytes, shifted by the page size field
`define SMWP_PAGE_BASE 24'h000004

// reset values
`define SMWP_RST_CS_N 6'h3f
`define SMWP_RST_LEN 10'h000
`define SMWP_RST_FLOAT 4'h0

`endif

// file: include/smwp_pkg.sv
/*
  types of the static memory wait and page controller.
  assumes nothing beyond a SystemVerilog compiler.
*/
package smwp_pkg;
  typedef enum logic [1:0] {SMWP_IDLE, SMWP_RELOAD, SMWP_ACCESS, SMWP_FLOAT} smwp_state_e;
  typedef logic [9:0] smwp_len_t;
endpackage

// file: src/smwp_static_mem_wait_page_ctrl.sv
/*
  access sequencer for external static memories: float waits, external
  wait (frozen/ready), slow clock waveforms and asynchronous page reads.
  assumes the configuration ports carry the set of the requested chip select
  and hold it while a request is offered; one clock, synchronous reset.
*/
`include "smwp_defines.svh"
// How it works
// R1 - without float optimization, float waits follow a read before next access
// R2 - read hold cycles already covering float time reduce the inserted waits
// R3 - wait mode 2 is frozen, 3 is ready, 0 ignores wait
// R4 - software gives hold cycles; no wait with page or slow mode
// R5 - wait is looked at only in the controlling strobe pulse phase
// R6 - frozen: counters and control outputs hold while wait asserted, then resume
// R7 - ready: wait tested in last pulse cycle, suspends, then hold phase
// R8 - ready: wait released early or asserted late changes nothing
// R9 - software programs pulse at least latency plus three cycles
// R10 - slow clock indication replaces programmed waveforms on all chip selects
// R11 - slow read 1,1,0,2,2; slow write 1,1,0,3,3 cycles
// R12 - a transfer started in slow mode finishes with slow lengths
// R13 - page reads only with page mode bit; pages 4 to 32 bytes
// R14 - pages aligned to size; high bits page address, low bits offset
// R15 - on 16-bit devices address bit 0 is dropped in page offset
// R16 - in page mode strobe and chip select share identical timing
// R17 - first page access uses cs pulse, later ones the strobe pulse
// R18 - page pulse values applied as given, without coherency checks
// R19 - entering or leaving slow mode adds a reload wait state
// R20 - float cycle count gives 0 to 15 float cycles
// R21 - page hit needs same chip select and page, no intervening access
// R22 - wait mode 1 behaves as disabled
// R23 - wait input passes a two-stage synchronizer before use
module smwp_static_mem_wait_page_ctrl import smwp_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // access request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [2:0] reqCs,
  input wire logic [23:0] reqAddr,
  output logic reqReady,
  output logic accessDone,
  // configuration of the requested chip select
  input wire logic [5:0] readStrobeSetupLen,
  input wire logic [6:0] readStrobePulseLen,
  input wire logic [5:0] csReadSetupLen,
  input wire logic [6:0] csReadPulseLen,
  input wire logic [8:0] readCycleLen,
  input wire logic [5:0] writeStrobeSetupLen,
  input wire logic [6:0] writeStrobePulseLen,
  input wire logic [5:0] csWriteSetupLen,
  input wire logic [6:0] csWritePulseLen,
  input wire logic [8:0] writeCycleLen,
  input wire logic readCtrlSelect,
  input wire logic writeCtrlSelect,
  input wire logic [1:0] extWaitModeField,
  input wire logic floatOptimizeBit,
  input wire logic [3:0] floatCycleCount,
  input wire logic pageModeEnableBit,
  input wire logic [1:0] pageSizeField,
  input wire logic bus16,
  // power manager and external device
  input wire logic slowClockMode,
  input wire logic extWaitN,
  // memory side
  output logic [5:0] chipSelectN,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic [23:0] memAddr
);

  // field decoders: high bit weights 128 / 256
  // cycle length keeps two high bits, so it reaches 256 * 3 + 127
  function automatic smwp_len_t setupLen(input logic [5:0] v);
    return {2'h0, v[5], 2'h0, v[4:0]};
  endfunction
  function automatic smwp_len_t pulseLen(input logic [6:0] v);
    return {1'h0, v[6], 2'h0, v[5:0]};
  endfunction
  function automatic smwp_len_t cycleLen(input logic [8:0] v);
    return {v[8:7], 1'h0, v[6:0]};
  endfunction

  smwp_state_e state;
  smwp_len_t cnt, eStrSetup, eStrPulse, eCsSetup, eCsPulse, eCycle;
  logic eWrite, eCtrlStrobe, eFloatOn;
  logic [1:0] eWaitMode;
  logic [3:0] eFloat, floatCnt;
  logic [2:0] eCs, pageCs;
  logic [23:0] pageAddr;
  logic pageValid, slowSeen;
  logic waitMeta, waitSyncN;

  // request decode and effective parameter set
  wire take = reqValid && reqReady;
  wire [23:0] pageLow = (`SMWP_PAGE_BASE << pageSizeField) - 24'h000001; // R14
  wire [23:0] reqPage = reqAddr & ~pageLow; // R14
  wire pageRead = pageModeEnableBit && !reqWrite && !slowClockMode; // R13
  // trade-off: one page tag for all chip selects; any other access breaks the page
  wire pageHit = pageRead && pageValid && reqCs == pageCs && reqPage == pageAddr; // R21
  wire smwp_len_t pageLen = pageHit ? pulseLen(readStrobePulseLen) : pulseLen(csReadPulseLen); // R17 R18
  wire [23:0] offsAddr = bus16 ? {reqAddr[23:1], 1'b0} : reqAddr; // R15
  wire needReload = slowClockMode != slowSeen; // R19

  // slow set wins over programmed set, page set over normal read
  wire smwp_len_t nStrSetup = slowClockMode ? (reqWrite ? `SMWP_SLOW_WR_STR_SETUP : `SMWP_SLOW_RD_STR_SETUP) :
    pageRead ? `SMWP_RST_LEN : setupLen(reqWrite ? writeStrobeSetupLen : readStrobeSetupLen); // R10 R11 R16
  wire smwp_len_t nStrPulse = slowClockMode ? (reqWrite ? `SMWP_SLOW_WR_STR_PULSE : `SMWP_SLOW_RD_STR_PULSE) :
    pageRead ? pageLen : pulseLen(reqWrite ? writeStrobePulseLen : readStrobePulseLen); // R10 R11 R16
  wire smwp_len_t nCsSetup = slowClockMode ? (reqWrite ? `SMWP_SLOW_WR_CS_SETUP : `SMWP_SLOW_RD_CS_SETUP) :
    pageRead ? `SMWP_RST_LEN : setupLen(reqWrite ? csWriteSetupLen : csReadSetupLen); // R10 R11 R16
  wire smwp_len_t nCsPulse = slowClockMode ? (reqWrite ? `SMWP_SLOW_WR_CS_PULSE : `SMWP_SLOW_RD_CS_PULSE) :
    pageRead ? pageLen : pulseLen(reqWrite ? csWritePulseLen : csReadPulseLen); // R10 R11 R16
  wire smwp_len_t nCycle = slowClockMode ? (reqWrite ? `SMWP_SLOW_WR_CYCLE : `SMWP_SLOW_RD_CYCLE) :
    pageRead ? pageLen : cycleLen(reqWrite ? writeCycleLen : readCycleLen); // R10 R11 R17
  // page and slow read waveforms give no hold, a strobe-controlled slow write one cycle; external wait stays out of them all
  wire [1:0] nWaitMode = (slowClockMode || pageRead) ? 2'h0 : extWaitModeField; // R4
  wire nCtrlStrobe = reqWrite ? writeCtrlSelect : readCtrlSelect;

  // phase decode of the running access
  wire smwp_len_t ctrlStart = eCtrlStrobe ? eStrSetup : eCsSetup;
  wire smwp_len_t ctrlEnd = ctrlStart + (eCtrlStrobe ? eStrPulse : eCsPulse);
  wire inPulse = cnt >= ctrlStart && cnt < ctrlEnd; // R5
  wire lastPulse = cnt == ctrlEnd - 10'h001; // R7
  // hazard: a wait shorter than the synchronizer delay may never be seen
  wire waitOn = !waitSyncN; // R23
  wire frozenMode = eWaitMode == `SMWP_WAIT_FROZEN; // R3
  wire readyMode = eWaitMode == `SMWP_WAIT_READY; // R3 R22
  wire freeze = state == SMWP_ACCESS && waitOn &&
    ((frozenMode && inPulse) || (readyMode && lastPulse)); // R5 R6 R7 R8
  // a cycle length of zero wraps to 1023 and runs 1024 cycles; software must program at least one
  wire accessEnd = state == SMWP_ACCESS && !freeze && cnt >= eCycle - 10'h001;
  // hold already spent counts against float time, so only the rest is waited
  wire smwp_len_t holdLen = eCycle > ctrlEnd ? eCycle - ctrlEnd : `SMWP_RST_LEN; // R2
  wire [3:0] floatExtra = {6'h00, eFloat} > holdLen ? 4'(10'(eFloat) - holdLen) : 4'h0; // R2 R20
  wire strOn = state == SMWP_ACCESS && cnt >= eStrSetup && cnt < 10'(eStrSetup + eStrPulse);
  wire csOn = state == SMWP_ACCESS && cnt >= eCsSetup && cnt < 10'(eCsSetup + eCsPulse);
  // chip select numbers above five select no line
  wire [5:0] csOneHot = 6'h01 << eCs;

  // wait input synchronizer; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      waitMeta <= 1'b1;
      waitSyncN <= 1'b1;
    end else begin
      waitMeta <= extWaitN; // R23
      waitSyncN <= waitMeta; // R23
    end
  end

  // a rising synchronized wait also trails the pin by two edges
  a_sync_release: assert property (@(posedge clock) disable iff (rst) // R23
    $rose(waitSyncN) |-> $past(extWaitN, 2) == 1'b1) else $error("wait release not two stages deep");

  // sequencer state and counters; counter holding is the freeze itself
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SMWP_IDLE;
      cnt <= `SMWP_RST_LEN;
      floatCnt <= `SMWP_RST_FLOAT;
      reqReady <= 1'b1;
      accessDone <= 1'b0;
    end else begin
      accessDone <= accessEnd;
      unique case (state)
        SMWP_IDLE: if (take) begin
          reqReady <= 1'b0;
          cnt <= `SMWP_RST_LEN;
          state <= needReload ? SMWP_RELOAD : SMWP_ACCESS; // R19
        end
        SMWP_RELOAD: state <= SMWP_ACCESS; // R19
        SMWP_ACCESS: if (accessEnd) begin
          if (eFloatOn && floatExtra != 4'h0) begin
            floatCnt <= floatExtra; // R1 R2
            state <= SMWP_FLOAT;
          end else begin
            state <= SMWP_IDLE;
            reqReady <= 1'b1;
          end
        end else if (!freeze) begin
          cnt <= cnt + 10'h001; // R6 R7
        end
        // counts down to one so reqReady returns right after the last float cycle
        SMWP_FLOAT: if (floatCnt == 4'h1) begin
          state <= SMWP_IDLE; // R1
          reqReady <= 1'b1;
        end else begin
          floatCnt <= floatCnt - 4'h1;
        end
      endcase
    end
  end

  // sequencer checks: freeze holds the counter, float waits keep the port closed
  a_freeze_count: assert property (@(posedge clock) disable iff (rst) // R6 R7
    freeze |=> $stable(cnt) && state == SMWP_ACCESS) else $error("counter moved during a freeze");
  a_float_closed: assert property (@(posedge clock) disable iff (rst) // R1
    state == SMWP_FLOAT |-> !reqReady) else $error("request taken during float wait");
  a_float_none: assert property (@(posedge clock) disable iff (rst) // R1 R2 R20
    (accessEnd && !(eFloatOn && floatExtra != 4'h0)) |=> reqReady && state == SMWP_IDLE)
    else $error("float wait inserted without need");
  a_write_no_float: assert property (@(posedge clock) disable iff (rst) // R1
    (accessEnd && eWrite) |=> state != SMWP_FLOAT) else $error("float wait after a write");
  a_reload_skip: assert property (@(posedge clock) disable iff (rst) // R19
    (take && !needReload) |=> state == SMWP_ACCESS) else $error("reload wait without mode change");
  a_done_single: assert property (@(posedge clock) disable iff (rst)
    accessDone |=> !accessDone) else $error("access done longer than one cycle");

  // parameter set latched at the start; slow set survives a mode change
  always_ff @(posedge clock) begin
    if (rst) begin
      {eStrSetup, eStrPulse, eCsSetup, eCsPulse, eCycle} <= {5{`SMWP_RST_LEN}};
      {eWrite, eCtrlStrobe, eFloatOn} <= 3'h0;
      eWaitMode <= 2'h0;
      eFloat <= `SMWP_RST_FLOAT;
      eCs <= 3'h0;
      memAddr <= 24'h000000;
    end else if (take) begin
      {eStrSetup, eStrPulse, eCsSetup, eCsPulse, eCycle} <= {nStrSetup, nStrPulse, nCsSetup, nCsPulse, nCycle}; // R12
      eWrite <= reqWrite;
      eCtrlStrobe <= nCtrlStrobe;
      eFloatOn <= !reqWrite && !floatOptimizeBit; // R1
      eWaitMode <= nWaitMode;
      eFloat <= floatCycleCount; // R20
      eCs <= reqCs;
      memAddr <= pageRead ? offsAddr : reqAddr; // R15
    end
  end

  // page tracking and slow mode memory; any non-page access breaks the page
  always_ff @(posedge clock) begin
    if (rst) begin
      pageValid <= 1'b0;
      pageCs <= 3'h0;
      pageAddr <= 24'h000000;
      slowSeen <= 1'b0;
    end else if (take) begin
      pageValid <= pageRead; // R21
      pageCs <= reqCs;
      pageAddr <= reqPage; // R14
      slowSeen <= slowClockMode; // R19
    end
  end

  // page checks: a hit runs on the strobe pulse, with no strobe setup
  a_page_hit_len: assert property (@(posedge clock) disable iff (rst) // R16 R17 R18
    (take && pageHit) |=> eCycle == pulseLen($past(readStrobePulseLen)) &&
      eCsPulse == eStrPulse && eStrSetup == 10'h000) else $error("page hit length wrong");

  // registered memory-side strobes, one cycle behind the counter
  always_ff @(posedge clock) begin
    if (rst) begin
      chipSelectN <= `SMWP_RST_CS_N;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
    end else begin
      chipSelectN <= csOn ? ~csOneHot : `SMWP_RST_CS_N; // R16
      readStrobeN <= !(strOn && !eWrite); // R16
      writeStrobeN <= !(strOn && eWrite);
    end
  end

  // output checks: page reads share one waveform, an idle bus stays released
  a_page_shared: assert property (@(posedge clock) disable iff (rst) // R16
    pageValid |-> readStrobeN == chipSelectN[eCs] && writeStrobeN) else $error("page strobe and select differ");
  a_idle_outputs: assert property (@(posedge clock) disable iff (rst) // R21
    (state == SMWP_IDLE && $past(state) == SMWP_IDLE) |->
      chipSelectN == `SMWP_RST_CS_N && readStrobeN && writeStrobeN) else $error("control lines active while idle");

  // ready suspension followed by its release
  sequence readyRelease;
    (freeze && readyMode) ##1 (!freeze && state == SMWP_ACCESS);
  endsequence
  sequence reloadThenAccess;
    state == SMWP_RELOAD ##1 state == SMWP_ACCESS;
  endsequence

  a_wait_mode_ignore: assert property (@(posedge clock) disable iff (rst) // R3 R22
    (state == SMWP_ACCESS && eWaitMode < 2'h2) |-> !freeze) else $error("wait honoured while disabled");
  a_wait_window: assert property (@(posedge clock) disable iff (rst) // R5
    (state == SMWP_ACCESS && !inPulse) |-> !freeze) else $error("wait seen outside pulse phase");
  a_frozen_hold: assert property (@(posedge clock) disable iff (rst) // R6
    (freeze && frozenMode) ##1 freeze |=> $stable(chipSelectN) && $stable(readStrobeN) && $stable(writeStrobeN))
    else $error("outputs moved while frozen");
  // ready mode: suspend only on the last pulse cycle, then go on into hold
  a_ready_last: assert property (@(posedge clock) disable iff (rst) // R7 R8
    (freeze && readyMode) |-> lastPulse ##1 $stable(cnt)) else $error("ready suspend off the last pulse cycle");
  a_ready_resume: assert property (@(posedge clock) disable iff (rst) // R7
    readyRelease |=> cnt == $past(cnt) + 10'h001 || state != SMWP_ACCESS)
    else $error("ready access did not resume");
  a_slow_lengths: assert property (@(posedge clock) disable iff (rst) // R11
    (take && slowClockMode) |=> eCycle == (eWrite ? 10'h003 : 10'h002) && eCsPulse == eCycle && eStrPulse == 10'h001)
    else $error("slow lengths wrong");
  a_page_first: assert property (@(posedge clock) disable iff (rst) // R17 R21
    (take && pageRead && !pageHit) |=> eCycle == pulseLen($past(csReadPulseLen)) && eCsSetup == 10'h000)
    else $error("page first access length wrong");
  a_reload_step: assert property (@(posedge clock) disable iff (rst) // R19
    (take && needReload) |=> reloadThenAccess) else $error("reload wait missing");
  a_float_wait: assert property (@(posedge clock) disable iff (rst) // R1 R2
    (accessEnd && eFloatOn && floatExtra == 4'h2) |=> state == SMWP_FLOAT ##1 state == SMWP_FLOAT ##1 reqReady)
    else $error("float wait length wrong");
  a_sync_depth: assert property (@(posedge clock) disable iff (rst) // R23
    $fell(waitSyncN) |-> $past(extWaitN, 2) == 1'b0) else $error("wait not two stages deep");

endmodule // smwp_static_mem_wait_page_ctrl

// file: test/smwp_mem_model.sv
/*
  partner: external device answering a strobe with its active-low wait.
  assumes strobes from the controller and wait timing set by the bench.
*/
module smwp_mem_model (
  // controller side
  input wire logic clock,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  // wait timing chosen by the bench
  input wire logic [7:0] waitDelay,
  input wire logic [7:0] waitLen,
  // device answer
  output logic extWaitN
);
  logic strobeN;
  logic lastStrobeN = 1'b1;
  logic [7:0] age = 8'hff;
  assign strobeN = readStrobeN & writeStrobeN;
  // age restarts at each strobe fall, saturates so an idle bus never waits
  always @(posedge clock) begin
    lastStrobeN <= strobeN;
    if (lastStrobeN && !strobeN) age <= 8'h01;
    else if (age != 8'hff) age <= age + 8'h01;
  end
  // latency is waitDelay; bench keeps it inside the pulse when it must be seen
  assign extWaitN = !(waitLen != 8'h00 && age >= waitDelay && age < waitDelay + waitLen);
endmodule // smwp_mem_model

// file: test/testbench.sv
/*
  bench: drives requests and configuration, models access length and
  float waits, compares at each completed access.
  assumes one controller and the wait partner; no package use needed.
*/
`define CHK(nm, ex, got) begin total_checks++; if ((ex) !== (got)) begin errors++; \
  $display("mismatch %s expected %0d seen %0d", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, readCtrlSelect = 1'b1;
  logic writeCtrlSelect = 1'b1, floatOptimizeBit = 1'b1, pageModeEnableBit = 1'b0, bus16 = 1'b0;
  logic slowClockMode = 1'b0, reqReady, accessDone, readStrobeN, writeStrobeN, extWaitN;
  logic [2:0] reqCs = 3'h0;
  logic [23:0] reqAddr = 24'h0, memAddr, b;
  logic [5:0] readStrobeSetupLen = 6'h01, csReadSetupLen = 6'h00, writeStrobeSetupLen = 6'h01;
  logic [5:0] csWriteSetupLen = 6'h00, chipSelectN;
  logic [6:0] readStrobePulseLen = 7'h0c, csReadPulseLen = 7'h14;
  logic [6:0] writeStrobePulseLen = 7'h0c, csWritePulseLen = 7'h14;
  logic [8:0] readCycleLen = 9'h014, writeCycleLen = 9'h014;
  logic [1:0] extWaitModeField = 2'h0, pageSizeField = 2'h0;
  logic [3:0] floatCycleCount = 4'h0;
  logic [7:0] waitDelay = 8'h00, waitLen = 8'h00;
  int errors = 0, total_checks = 0, cycles = 0, seed = 32'h732f, lastPg = -1, lastCs = 0, n, m;
  bit lastSlow = 1'b0;
  // wait cases: mode, delay, length, least stall, spread
  localparam int WM[7] = '{0, 1, 2, 3, 3, 2, 3};
  localparam int WD[7] = '{1, 1, 13, 13, 1, 1, 1};
  localparam int WL[7] = '{8, 8, 3, 3, 2, 4, 18};
  localparam int WS[7] = '{0, 0, 0, 0, 0, 3, 4};
  localparam int WX[7] = '{0, 0, 0, 0, 0, 2, 8};
  smwp_static_mem_wait_page_ctrl i_dut (.clock, .rst, .reqValid, .reqWrite, .reqCs, .reqAddr, .reqReady,
    .accessDone, .readStrobeSetupLen, .readStrobePulseLen, .csReadSetupLen, .csReadPulseLen, .readCycleLen,
    .writeStrobeSetupLen, .writeStrobePulseLen, .csWriteSetupLen, .csWritePulseLen, .writeCycleLen,
    .readCtrlSelect, .writeCtrlSelect, .extWaitModeField, .floatOptimizeBit, .floatCycleCount, .pageModeEnableBit,
    .pageSizeField, .bus16, .slowClockMode, .extWaitN, .chipSelectN, .readStrobeN, .writeStrobeN, .memAddr);
  smwp_mem_model i_mem (.clock(clock), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .waitDelay(waitDelay), .waitLen(waitLen), .extWaitN(extWaitN));
  // free running clock and hang guard
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report;
    end
  end
  task final_report;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one access; model of length and float waits worked out at request time
  task acc(input bit wr, input logic [2:0] cs, input logic [23:0] ad, input int st, input int sp,
    input bit flip);
    int e, f, c, h, pg;
    bit pr, hit;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqCs <= cs;
    reqAddr <= ad;
    pr = !wr && pageModeEnableBit && !slowClockMode;
    pg = ad >> (2 + pageSizeField);
    hit = pr && lastPg == pg && lastCs == cs;
    c = wr ? writeCycleLen : readCycleLen;
    e = slowClockMode ? (wr ? 3 : 2) : pr ? (hit ? readStrobePulseLen : csReadPulseLen) : c;
    e = e + st + (slowClockMode != lastSlow);
    h = c - (readCtrlSelect ? readStrobeSetupLen + readStrobePulseLen : csReadSetupLen + csReadPulseLen);
    f = (wr || floatOptimizeBit || slowClockMode || pr || floatCycleCount <= h) ? 0 : floatCycleCount - h;
    lastPg = pr ? pg : -1;
    lastCs = cs;
    lastSlow = slowClockMode;
    @(posedge clock);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      if (flip && n == 0) slowClockMode <= !slowClockMode;
      #1 n++;
      if (pr) `CHK("strobe vs select", chipSelectN[cs], readStrobeN)
    end while (accessDone !== 1'b1 && n < 1000);
    `CHK("latency", e, (n >= e && n <= e + sp) ? e : n)
    `CHK("address", (pr && bus16) ? {ad[23:1], 1'b0} : ad, memAddr)
    m = 0;
    while (reqReady !== 1'b1 && m < 100) begin
      @(posedge clock);
      #1 m++;
    end
    `CHK("float", f, m)
    @(posedge clock);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 `CHK("reset", {10'h2ff, 24'h0}, {reqReady, accessDone, chipSelectN, readStrobeN, writeStrobeN, memAddr})
    @(posedge clock);
    for (int i = 0; i < 7; i++) begin
      extWaitModeField <= WM[i];
      waitDelay <= WD[i];
      waitLen <= WL[i];
      acc(i[0], 3'h1, 24'h000100, WS[i], WX[i], 1'b0);
    end
    waitLen <= 8'h00;
    floatOptimizeBit <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      floatCycleCount <= (i == 0) ? 4'hf : (i == 1) ? 4'ha : $random(seed);
      readCtrlSelect <= i[0];
      readCycleLen <= 9'h014 + i;
      acc(1'b0, i % 6, $random(seed), 0, 0, 1'b0);
    end
    acc(1'b1, 3'h2, 24'h000040, 0, 0, 1'b0);
    floatOptimizeBit <= 1'b1;
    slowClockMode <= 1'b1;
    acc(1'b0, 3'h0, 24'h000010, 0, 0, 1'b0);
    acc(1'b1, 3'h5, 24'h000020, 0, 0, 1'b0);
    acc(1'b0, 3'h0, 24'h000030, 0, 0, 1'b1);
    acc(1'b0, 3'h0, 24'h000030, 0, 0, 1'b0);
    pageModeEnableBit <= 1'b1;
    csReadPulseLen <= 7'h03;
    readStrobePulseLen <= 7'h06;
    for (int p = 0; p < 4; p++) begin
      pageSizeField <= p;
      bus16 <= p[0];
      b = $random(seed);
      b[7:0] = 8'h00;
      acc(1'b0, 3'h2, b, 0, 0, 1'b0);
      acc(1'b0, 3'h2, b | ($random(seed) & ((4 << p) - 1)), 0, 0, 1'b0);
      acc(1'b0, 3'h2, b + (4 << p), 0, 0, 1'b0);
    end
    acc(1'b0, 3'h3, b, 0, 0, 1'b0);
    acc(1'b0, 3'h2, b, 0, 0, 1'b0);
    pageModeEnableBit <= 1'b0;
    acc(1'b0, 3'h2, b, 0, 0, 1'b0);
    final_report;
  end
endmodule // testbench
